//--- design/mbra_frame.sv
// Purpose: slave frame handler for read (0x03) and write (0x10) register requests
// Assumes: bytes arrive one a cycle at most, rx last marks the final byte of a frame
// Notes:   writes are applied only after the whole frame checks good
`timescale 1ns/1ns
module mbra_frame
  import mbra_pkg::*;
#(
  parameter logic [15:0] REG_LO   = 16'h2000,
  parameter logic [15:0] REG_HI   = 16'h30ff,
  parameter int          BUF_SIZE = 256
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // configuration
  input  wire logic        slave_addr_set,
  input  wire logic [7:0]  slave_addr,
  // byte stream from link
  input  wire mbra_byte_s  rx,
  // byte stream to link
  output mbra_byte_s       tx,
  input  wire logic        tx_ready,
  // register space
  output mbra_reg_s        reg_req,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_bad_value
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    mbra_state_e st;
    logic [7:0]  cnt;
    logic [7:0]  len;
    logic [15:0] crc;
    logic [7:0]  fn;
    logic [15:0] start;
    logic [15:0] num;
    logic [7:0]  bcnt;
    logic [7:0]  exc;
    logic        err;
    logic [15:0] word;
    logic        reg_rd;
    logic        reg_wr;
    logic [15:0] reg_addr;
    logic [15:0] reg_wdata;
    mbra_byte_s  out;
  } mbra_core_s;

  mbra_core_s q;
  mbra_core_s next_q;
  logic [7:0] buffer [BUF_SIZE];
  logic [7:0] my_addr;

  // one byte through the crc register, lsb first
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ MBRA_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // number of bytes a good request must have
  function automatic logic [7:0] want_len(input logic [7:0] f, input logic [7:0] bc);
    if (f == MBRA_FN_WRITE) begin
      return 8'(MBRA_WR_HDR + bc);
    end
    return MBRA_RD_LEN;
  endfunction

  assign my_addr = slave_addr_set ? slave_addr : MBRA_ADDR_DEFAULT;
  assign tx      = q.out;
  assign reg_req = '{rd: q.reg_rd, wr: q.reg_wr, addr: q.reg_addr, wdata: q.reg_wdata};

  // ************************************************************
  // receive buffer, written only while receiving
  // ************************************************************
  always_ff @(posedge clock) begin
    if (q.st == MBRA_RX && rx.valid && q.cnt < 8'(BUF_SIZE - 1)) begin
      buffer[q.cnt] <= rx.data;
    end
  end

  // ************************************************************
  // frame sequencing
  // ************************************************************
  always_comb begin
    logic [15:0] last_reg;
    logic [7:0]  idx;
    logic [7:0]  b;
    logic [7:0]  hi;
    next_q        = q;
    last_reg      = 16'h0000;
    idx           = 8'h00;
    b             = 8'h00;
    hi            = 8'h00;
    next_q.reg_rd = 1'b0;
    next_q.reg_wr = 1'b0;
    if (q.out.valid && tx_ready) begin
      next_q.out.valid = 1'b0;
      next_q.out.last  = 1'b0;
    end
    case (q.st)
      MBRA_RX: begin
        if (rx.valid) begin
          next_q.cnt = 8'(q.cnt + 8'h01);
          if (q.cnt == MBRA_IDX_FN) next_q.fn = rx.data;
          if (q.cnt == MBRA_IDX_AHI) next_q.start[15:8] = rx.data;
          if (q.cnt == MBRA_IDX_ALO) next_q.start[7:0] = rx.data;
          if (q.cnt == MBRA_IDX_CHI) next_q.num[15:8] = rx.data;
          if (q.cnt == MBRA_IDX_CLO) next_q.num[7:0] = rx.data;
          if (q.cnt == MBRA_IDX_BC) next_q.bcnt = rx.data;
          // crc over every byte incl. its own: good frame leaves zero
          next_q.crc = crc_byte(q.crc, rx.data);
          if (rx.last) begin
            next_q.cnt = 8'h00;
            next_q.len = 8'(q.cnt + 8'h01);
            next_q.crc = MBRA_CRC_INIT;
            // silent on bad crc, wrong address, broadcast, bad length
            if (crc_byte(q.crc, rx.data) == 16'h0000 && buffer[0] == my_addr
                && buffer[0] != MBRA_ADDR_BCAST && q.cnt < 8'(BUF_SIZE - 1)) begin
              next_q.st = MBRA_EXEC;
            end
          end
        end
      end
      MBRA_EXEC: begin
        last_reg   = 16'(q.start + q.num - 16'h0001);
        next_q.err = 1'b1;
        // checks in priority order
        if (q.fn != MBRA_FN_READ && q.fn != MBRA_FN_WRITE) begin
          next_q.exc = MBRA_EX_FUNC;
        end else if (q.len != want_len(q.fn, q.bcnt)) begin
          next_q.err = 1'b0;
          next_q.st  = MBRA_RX;
        end else if (q.start < REG_LO
                     || (|q.num && (last_reg > REG_HI || last_reg < q.start))) begin
          next_q.exc = MBRA_EX_REG;
        end else if (q.num == 16'h0000
                     || (q.fn == MBRA_FN_READ && q.num > MBRA_RD_MAX)
                     || (q.fn == MBRA_FN_WRITE && (q.num > MBRA_WR_MAX
                         || {8'h00, q.bcnt} != 16'(q.num << 1)))) begin
          next_q.exc = MBRA_EX_COUNT;
        end else if (q.fn == MBRA_FN_WRITE && reg_bad_value) begin
          next_q.exc = MBRA_EX_DATA;
        end else begin
          next_q.err = 1'b0;
        end
        if (next_q.st == MBRA_EXEC) begin
          next_q.st  = MBRA_TX;
          next_q.cnt = 8'h00;
          next_q.crc = MBRA_CRC_INIT;
          next_q.len = next_q.err ? MBRA_EX_RSP_LEN
                     : (q.fn == MBRA_FN_WRITE) ? MBRA_WR_RSP_LEN
                     : 8'(MBRA_RD_RSP_HDR + 8'(q.num << 1));
        end
      end
      MBRA_TX: begin
        if (!q.out.valid || tx_ready) begin
          idx = q.cnt;
          case (idx)
            8'h00: b = buffer[0];
            8'h01: b = q.fn | (q.err ? MBRA_FN_ERRBIT : 8'h00);
            default: begin
              if (q.err) begin
                b = q.exc;
              end else if (q.fn == MBRA_FN_WRITE) begin
                b = buffer[idx];
                hi = 8'(MBRA_IDX_BC + 8'h01 + 8'(idx - MBRA_IDX_ALO));
                // apply the words the request carries, at most the first two (at ALO and CLO), as a low echo byte goes out
                if (idx[0] && idx <= MBRA_IDX_CLO && 8'(idx - MBRA_IDX_ALO) < q.bcnt) begin
                  next_q.reg_wr    = 1'b1;
                  next_q.reg_addr  = 16'(q.start + 16'(idx - MBRA_IDX_ALO) / 16'h0002);
                  next_q.reg_wdata = {buffer[hi], buffer[8'(hi + 8'h01)]};
                end
              end else if (idx == MBRA_IDX_AHI) begin
                b = 8'(q.num << 1);
              end else begin
                b = (idx[0]) ? reg_rdata[15:8] : q.word[7:0];
                if (idx[0]) next_q.word = reg_rdata;
              end
            end
          endcase
          // read data: fetch the word one byte before its high byte
          if (!q.err && q.fn == MBRA_FN_READ && idx >= MBRA_IDX_AHI && !idx[0]
              && 8'(idx + 8'h01) != q.len) begin
            next_q.reg_rd   = 1'b1;
            next_q.reg_addr = 16'(q.start + 16'(idx - MBRA_IDX_AHI) / 16'h0002);
          end
          next_q.out = '{valid: 1'b1, data: b, last: 1'b0};
          next_q.crc = crc_byte(q.crc, b);
          next_q.cnt = 8'(q.cnt + 8'h01);
          if (8'(q.cnt + 8'h01) == q.len) begin
            next_q.st  = MBRA_CRC;
            next_q.cnt = 8'h00;
          end
        end
      end
      MBRA_CRC: begin
        if (!q.out.valid || tx_ready) begin
          // low byte, then high byte
          next_q.out = '{valid: 1'b1, data: (q.cnt == 8'h00) ? q.crc[7:0] : q.crc[15:8],
                         last: q.cnt != 8'h00};
          next_q.cnt = 8'(q.cnt + 8'h01);
          if (q.cnt != 8'h00) begin
            next_q.st  = MBRA_RX;
            next_q.cnt = 8'h00;
            next_q.crc = MBRA_CRC_INIT;
          end
        end
      end
      default: next_q.st = MBRA_RX;
    endcase
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q <= '{st: MBRA_RX, crc: MBRA_CRC_INIT, default: '0};
    end else begin
      q <= next_q;
    end
  end

endmodule

//--- inc/mbra_pkg.sv
// Purpose: constants and carriers for the serial register frame handler
// Assumes: one byte stream in, one byte stream out, frame end marked by the link
// Notes:   register map bounds are parameters of the top module
package mbra_pkg;
  localparam logic [7:0]  MBRA_ADDR_DEFAULT = 8'h01;
  localparam logic [7:0]  MBRA_ADDR_BCAST   = 8'h00;
  localparam logic [7:0]  MBRA_FN_READ      = 8'h03;
  localparam logic [7:0]  MBRA_FN_WRITE     = 8'h10;
  localparam logic [7:0]  MBRA_FN_ERRBIT    = 8'h80;
  localparam logic [7:0]  MBRA_EX_FUNC      = 8'h01;
  localparam logic [7:0]  MBRA_EX_REG       = 8'h02;
  localparam logic [7:0]  MBRA_EX_COUNT     = 8'h03;
  localparam logic [7:0]  MBRA_EX_DATA      = 8'h04;
  localparam logic [15:0] MBRA_CRC_INIT     = 16'hffff;
  localparam logic [15:0] MBRA_CRC_POLY     = 16'ha001;
  localparam logic [15:0] MBRA_RD_MAX       = 16'h006a;
  localparam logic [15:0] MBRA_WR_MAX       = 16'h0068;
  localparam logic [7:0]  MBRA_RD_LEN       = 8'h08;
  localparam logic [7:0]  MBRA_WR_HDR       = 8'h09;
  localparam logic [7:0]  MBRA_IDX_FN       = 8'h01;
  localparam logic [7:0]  MBRA_IDX_AHI      = 8'h02;
  localparam logic [7:0]  MBRA_IDX_ALO      = 8'h03;
  localparam logic [7:0]  MBRA_IDX_CHI      = 8'h04;
  localparam logic [7:0]  MBRA_IDX_CLO      = 8'h05;
  localparam logic [7:0]  MBRA_IDX_BC       = 8'h06;
  localparam logic [7:0]  MBRA_WR_RSP_LEN   = 8'h06;
  localparam logic [7:0]  MBRA_EX_RSP_LEN   = 8'h03;
  localparam logic [7:0]  MBRA_RD_RSP_HDR   = 8'h03;

  // byte stream carrier
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
  } mbra_byte_s;

  // register-space access carrier
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mbra_reg_s;

  typedef enum logic [3:0] {
    MBRA_RX   = 4'b0001,
    MBRA_EXEC = 4'b0010,
    MBRA_TX   = 4'b0100,
    MBRA_CRC  = 4'b1000
  } mbra_state_e;
endpackage

//--- tb/mbra_frame_asserts.sv
// Purpose: port assertions for the frame handler
// Assumes: one clock, synchronous active-low reset
// Notes:   bound from the bench top file
`timescale 1ns/1ns
module mbra_frame_asserts
  import mbra_pkg::*;
#(
  parameter logic [15:0] REG_LO = 16'h2000,
  parameter logic [15:0] REG_HI = 16'h30ff
) (
  // clock, reset, configuration
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       slave_addr_set,
  input wire logic [7:0] slave_addr,
  // streams and register space
  input wire mbra_byte_s rx,
  input wire mbra_byte_s tx,
  input wire logic       tx_ready,
  input wire mbra_reg_s  reg_req
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic sop;
  // marks that the next reply byte opens a frame
  always_ff @(posedge clock) begin
    if (!rst_n) sop <= 1'b1;
    else if (tx.valid && tx_ready) sop <= tx.last;
  end
  property p_hold; tx.valid && !tx_ready |=> tx.valid && $stable(tx); endproperty
  a_hold: assert property (p_hold) else $error("reply byte dropped before taken");
  property p_addr;
    sop && tx.valid |-> tx.data == (slave_addr_set ? slave_addr : 8'h01) && tx.data != 8'h00;
  endproperty
  a_addr: assert property (p_addr) else $error("reply address wrong");
  property p_rise;
    $rose(tx.valid) |-> $past(rx.last, 2) || $past(rx.last, 3) || $past(rx.last, 4);
  endproperty
  a_rise: assert property (p_rise) else $error("reply not tied to frame end");
  property p_end; tx.valid && tx_ready && tx.last |=> !tx.valid; endproperty
  a_end: assert property (p_end) else $error("reply runs past last byte");
  property p_lastv; tx.last |-> tx.valid; endproperty
  a_lastv: assert property (p_lastv) else $error("last without valid");
  property p_wr;
    reg_req.wr |-> tx.valid && reg_req.addr >= REG_LO && reg_req.addr <= REG_HI;
  endproperty
  a_wr: assert property (p_wr) else $error("write outside map or reply");
  property p_rd; reg_req.rd |-> reg_req.addr >= REG_LO && reg_req.addr <= REG_HI; endproperty
  a_rd: assert property (p_rd) else $error("read outside map");
  property p_rst; $rose(rst_n) |-> !tx.valid && !reg_req.rd && !reg_req.wr; endproperty
  a_rst: assert property (p_rst) else $error("outputs busy after reset");
  property p_excl; reg_req.rd |-> !reg_req.wr; endproperty
  a_excl: assert property (p_excl) else $error("read and write together");
endmodule

//--- tb/mbra_frame_tb_top.sv
// Purpose: self-checking bench for the frame handler
// Assumes: one byte per cycle into the handler
// Notes:   register space answers from a fixed pattern
`timescale 1ns/1ns
module mbra_frame_tb_top;
  import mbra_pkg::*;
  typedef logic [7:0] mbra_bq_t[$];
  logic clock, rst_n, slave_addr_set, tx_ready, reg_bad_value, slow;
  logic [7:0] slave_addr;
  logic [15:0] reg_rdata, wa, wd;
  mbra_byte_s rx, tx;
  mbra_reg_s reg_req;
  int bad_count = 0;
  int checks = 0;
  mbra_frame uut (.clock(clock), .rst_n(rst_n), .slave_addr_set(slave_addr_set),
    .slave_addr(slave_addr), .rx(rx), .tx(tx), .tx_ready(tx_ready), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_bad_value(reg_bad_value));
  mbra_host_sink mdl (.clock(clock), .tx(tx), .slow(slow), .tx_ready(tx_ready));
  function automatic logic [15:0] rv(input logic [15:0] a);
    return a == 16'h3000 ? 16'h4048 : a == 16'h3001 ? 16'hf5c3 : a ^ 16'h00ff;
  endfunction
  assign reg_rdata = rv(reg_req.addr);
  // last register write seen
  always @(posedge clock) if (reg_req.wr) begin wa <= reg_req.addr; wd <= reg_req.wdata; end
  function automatic logic [15:0] crc16(input mbra_bq_t q);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction
  function automatic mbra_bq_t rd_rsp(logic [7:0] a, logic [15:0] s, logic [7:0] n);
    mbra_bq_t e;
    logic [15:0] v;
    e = '{a, 8'h03, {n[6:0], 1'b0}};
    for (int i = 0; i < n; i++) begin
      v = rv(s + 16'(i));
      e.push_back(v[15:8]);
      e.push_back(v[7:0]);
    end
    return e;
  endfunction
  task automatic oops(input string m);
    bad_count++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask
  // send a frame with crc, compare the reply with crc added
  task automatic xfer(input mbra_bq_t q, input mbra_bq_t e, input bit bad);
    logic [15:0] c;
    int k;
    c = crc16(q) ^ {15'h0000, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    if (e.size() > 0) begin
      c = crc16(e);
      e.push_back(c[7:0]);
      e.push_back(c[15:8]);
    end
    mdl.q.delete();
    k = mdl.lasts;
    foreach (q[i]) begin
      rx = '{1'b1, q[i], i == q.size() - 1};
      @(posedge clock);
      #1;
    end
    rx = '0;
    if (e.size() == 0) repeat (40) @(posedge clock);
    for (int n = 0; e.size() > 0 && n < 1000 && mdl.lasts == k; n++) @(posedge clock);
    repeat (2) @(posedge clock);
    #1;
    checks++;
    if (mdl.q.size() != e.size()) oops("reply length");
    else foreach (e[i]) if (mdl.q[i] !== e[i]) oops("reply byte");
  endtask
  task automatic t_read();
    slow = 1'b1;
    xfer('{8'h01, 8'h03, 8'h20, 8'h00, 8'h00, 8'h02}, rd_rsp(8'h01, 16'h2000, 8'h02), 0);
    xfer('{8'h01, 8'h03, 8'h30, 8'h00, 8'h00, 8'h02}, rd_rsp(8'h01, 16'h3000, 8'h02), 0);
    slow = 1'b0;
  endtask
  task automatic t_count();
    xfer('{8'h01, 8'h03, 8'h20, 8'h00, 8'h00, 8'h6a}, rd_rsp(8'h01, 16'h2000, 8'h6a), 0);
    xfer('{8'h01, 8'h03, 8'h20, 8'h00, 8'h00, 8'h6b}, '{8'h01, 8'h83, 8'h03}, 0);
    xfer('{8'h01, 8'h03, 8'h20, 8'h00, 8'h00, 8'h00}, '{8'h01, 8'h83, 8'h03}, 0);
  endtask
  task automatic t_prio();
    xfer('{8'h01, 8'h03, 8'h10, 8'h00, 8'h00, 8'h00}, '{8'h01, 8'h83, 8'h02}, 0);
    xfer('{8'h01, 8'h03, 8'h30, 8'hff, 8'h00, 8'h02}, '{8'h01, 8'h83, 8'h02}, 0);
    xfer('{8'h01, 8'h05, 8'h10, 8'h00, 8'h00, 8'h00}, '{8'h01, 8'h85, 8'h01}, 0);
  endtask
  task automatic t_write();
    xfer('{8'h01, 8'h10, 8'h30, 8'h02, 8'h00, 8'h01, 8'h02, 8'h00, 8'h01},
      '{8'h01, 8'h10, 8'h30, 8'h02, 8'h00, 8'h01}, 0);
    checks++;
    if (wa !== 16'h3002 || wd !== 16'h0001) oops("write pulse");
    xfer('{8'h01, 8'h10, 8'h30, 8'h04, 8'h00, 8'h02, 8'h04, 8'h12, 8'h34, 8'h56, 8'h78},
      '{8'h01, 8'h10, 8'h30, 8'h04, 8'h00, 8'h02}, 0);
    checks++;
    if (wa !== 16'h3005 || wd !== 16'h5678) oops("second word write");
    xfer('{8'h01, 8'h10, 8'h30, 8'h02, 8'h00, 8'h00, 8'h00}, '{8'h01, 8'h90, 8'h03}, 0);
    xfer('{8'h01, 8'h10, 8'h10, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00, 8'h01},
      '{8'h01, 8'h90, 8'h02}, 0);
    reg_bad_value = 1'b1;
    xfer('{8'h01, 8'h10, 8'h30, 8'h02, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34},
      '{8'h01, 8'h90, 8'h04}, 0);
    reg_bad_value = 1'b0;
  endtask
  // reset in mid-frame must drop the partial frame
  task automatic t_reset();
    rx = '{1'b1, 8'h01, 1'b0};
    @(posedge clock);
    #1;
    rx = '0;
    rst_n = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    rst_n = 1'b1;
    xfer('{8'h01, 8'h03, 8'h20, 8'h04, 8'h00, 8'h01}, rd_rsp(8'h01, 16'h2004, 8'h01), 0);
  endtask
  task automatic t_silent();
    xfer('{8'h00, 8'h03, 8'h20, 8'h00, 8'h00, 8'h01}, '{}, 0);
    xfer('{8'h07, 8'h03, 8'h20, 8'h00, 8'h00, 8'h01}, '{}, 0);
    xfer('{8'h01, 8'h03, 8'h20, 8'h00, 8'h00, 8'h01}, '{}, 1);
    xfer('{8'h01, 8'h03, 8'h20, 8'h00, 8'h00, 8'h01, 8'h00}, '{}, 0);
    slave_addr_set = 1'b1;
    slave_addr = 8'h22;
    xfer('{8'h01, 8'h03, 8'h20, 8'h00, 8'h00, 8'h01}, '{}, 0);
    xfer('{8'h22, 8'h03, 8'h20, 8'h00, 8'h00, 8'h01}, rd_rsp(8'h22, 16'h2000, 8'h01), 0);
  endtask
  task automatic give_verdict();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // watchdog against a hung reply
  initial begin
    #200000;
    bad_count++;
    give_verdict();
  end
  initial begin
    rst_n = 1'b0;
    rx = '0;
    slave_addr_set = 1'b0;
    slave_addr = 8'h00;
    reg_bad_value = 1'b0;
    slow = 1'b0;
    repeat (6) @(posedge clock);
    #1 rst_n = 1'b1;
    t_read();
    t_count();
    t_prio();
    t_write();
    t_reset();
    t_silent();
    give_verdict();
  end
endmodule
bind mbra_frame mbra_frame_asserts #(.REG_LO(REG_LO), .REG_HI(REG_HI)) u_chk (.clock(clock),
  .rst_n(rst_n), .slave_addr_set(slave_addr_set), .slave_addr(slave_addr), .rx(rx),
  .tx(tx), .tx_ready(tx_ready), .reg_req(reg_req));

//--- tb/mbra_host_sink.sv
// Purpose: bus master side taking the reply stream
// Assumes: ready may stall every other cycle
// Notes:   counts frame ends for the bench
`timescale 1ns/1ns
module mbra_host_sink
  import mbra_pkg::*;
(
  // clock and reply stream
  input  wire logic       clock,
  input  wire mbra_byte_s tx,
  input  wire logic       slow,
  output logic            tx_ready
);
  logic [7:0] q[$];
  int         lasts;
  initial begin
    tx_ready = 1'b0;
    lasts = 0;
  end
  // take bytes on valid and ready, stall when slow
  always @(posedge clock) begin
    if (tx.valid && tx_ready) begin
      q.push_back(tx.data);
      if (tx.last) lasts++;
    end
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
endmodule
